// ### hdl/nofs_selector.v
// network output function selector: sixteen selectable status bits
// assumes a classic wishbone master on clk_i; pin inputs asynchronous,
// driver state inputs from logic on clk_i
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "nofs_defines.vh"

// Function
// - sixteen slots, each with own selection code
// - code zero means unused slot
// - codes 1-7 echo command inputs
// - codes 8-13 echo direct select inputs
// - codes 16-18 echo release, current-on, stop
// - codes 32-47 give general flags 0-15
// - codes 48-53 echo data select inputs
// - codes 60-63 echo limit and sensor inputs
// - code 65 carries alarm state
// - code 66 carries warning state
// - code 67 carries ready state
// - code 68 carries motor moving state
// - code 69 carries positioning done state
// - code 70 carries home position state
// - code 71 carries torque limit state
// - code 72 carries shaft timing pulse
// - codes 73-75 carry area windows 1-3
// - code 80 carries internal busy state
// - code 82 carries main power state
// - every bit active high
// - reset codes 48,49,50,4,70,67,66,65,80,73,74,75,72,68,69,71
module nofs_selector (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// command pins
	input wire forward_cmd_i,
	input wire reverse_cmd_i,
	input wire homing_cmd_i,
	input wire start_cmd_i,
	input wire sequential_start_i,
	input wire plus_jog_i,
	input wire minus_jog_i,
	input wire [5:0] direct_select_i,
	input wire motor_release_i,
	input wire current_on_i,
	input wire stop_cmd_i,
	input wire [5:0] data_select_i,
	// sensor pins
	input wire plus_limit_i,
	input wire minus_limit_i,
	input wire home_sensor_i,
	input wire slit_sensor_i,
	// driver states, same clock
	input wire alarm_flag_i,
	input wire warning_flag_i,
	input wire ready_flag_i,
	input wire moving_flag_i,
	input wire position_done_flag_i,
	input wire home_position_flag_i,
	input wire torque_limit_flag_i,
	input wire shaft_timing_pulse_i,
	input wire area_window_flag_1_i,
	input wire area_window_flag_2_i,
	input wire area_window_flag_3_i,
	input wire internal_busy_flag_i,
	input wire main_power_flag_i,
	// network status bits
	output wire [15:0] network_status_o
);

	localparam PIN_W = 26;
	localparam STATE_W = 13;

	// address hit on one word
	function adr_hit;
		input [7:0] adr;
		input [7:0] base;
		begin
			adr_hit = (adr[7:2] == base[7:2]);
		end
	endfunction

	// slot window hit
	function sel_hit;
		input [7:0] adr;
		begin
			sel_hit = (adr[7:2] <= `NOFS_ADR_SEL_LAST >> 2);
		end
	endfunction

	// reset code of one slot
	function [6:0] rst_code;
		input [3:0] idx;
		begin
			case (idx)
				4'h0: rst_code = `NOFS_RST_SEL0;
				4'h1: rst_code = `NOFS_RST_SEL1;
				4'h2: rst_code = `NOFS_RST_SEL2;
				4'h3: rst_code = `NOFS_RST_SEL3;
				4'h4: rst_code = `NOFS_RST_SEL4;
				4'h5: rst_code = `NOFS_RST_SEL5;
				4'h6: rst_code = `NOFS_RST_SEL6;
				4'h7: rst_code = `NOFS_RST_SEL7;
				4'h8: rst_code = `NOFS_RST_SEL8;
				4'h9: rst_code = `NOFS_RST_SEL9;
				4'ha: rst_code = `NOFS_RST_SEL10;
				4'hb: rst_code = `NOFS_RST_SEL11;
				4'hc: rst_code = `NOFS_RST_SEL12;
				4'hd: rst_code = `NOFS_RST_SEL13;
				4'he: rst_code = `NOFS_RST_SEL14;
				default: rst_code = `NOFS_RST_SEL15;
			endcase
		end
	endfunction

	// pin inputs gathered for synchronising
	wire [PIN_W-1:0] pin_raw;
	assign pin_raw = {
		slit_sensor_i,
		home_sensor_i,
		minus_limit_i,
		plus_limit_i,
		data_select_i[5],
		data_select_i[4],
		data_select_i[3],
		data_select_i[2],
		data_select_i[1],
		data_select_i[0],
		stop_cmd_i,
		current_on_i,
		motor_release_i,
		direct_select_i[5],
		direct_select_i[4],
		direct_select_i[3],
		direct_select_i[2],
		direct_select_i[1],
		direct_select_i[0],
		minus_jog_i,
		plus_jog_i,
		sequential_start_i,
		start_cmd_i,
		homing_cmd_i,
		reverse_cmd_i,
		forward_cmd_i
	};

	// driver states gathered
	wire [STATE_W-1:0] state_vec;
	assign state_vec = {
		main_power_flag_i,
		internal_busy_flag_i,
		area_window_flag_3_i,
		area_window_flag_2_i,
		area_window_flag_1_i,
		shaft_timing_pulse_i,
		torque_limit_flag_i,
		home_position_flag_i,
		position_done_flag_i,
		moving_flag_i,
		ready_flag_i,
		warning_flag_i,
		alarm_flag_i
	};

	reg [PIN_W-1:0] pin_meta_reg;
	reg [PIN_W-1:0] pin_sync_reg;
	reg [6:0] sel_reg [0:15];
	reg [15:0] flags_reg;
	reg [15:0] status_reg;
	reg [15:0] status_next;
	reg [127:0] src_next;
	reg ack_reg;
	reg [31:0] dat_reg;
	reg [31:0] dat_next;

	// synchronised pin fields
	wire [6:0] cmd_s;
	wire [5:0] ms_s;
	wire [2:0] ctl_s;
	wire [5:0] dsel_s;
	wire [3:0] sens_s;
	assign cmd_s = pin_sync_reg[6:0];
	assign ms_s = pin_sync_reg[12:7];
	assign ctl_s = pin_sync_reg[15:13];
	assign dsel_s = pin_sync_reg[21:16];
	assign sens_s = pin_sync_reg[25:22];

	// bus request decode
	wire req;
	wire wr_en;
	assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr_en = req & wb_we_i;
	wire slot_wr;
	wire flags_wr;
	assign slot_wr = wr_en & wb_sel_i[0] & sel_hit(wb_adr_i);
	assign flags_wr = wr_en & adr_hit(wb_adr_i, `NOFS_ADR_FLAGS);

	// two-stage pin synchroniser
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_reg <= {PIN_W{1'b0}};
			pin_sync_reg <= {PIN_W{1'b0}};
		end else if (ce_i) begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// selection registers, one per slot
	always @(posedge clk_i) begin
		if (rst_i) begin
			sel_reg[0] <= rst_code(4'h0);
			sel_reg[1] <= rst_code(4'h1);
			sel_reg[2] <= rst_code(4'h2);
			sel_reg[3] <= rst_code(4'h3);
			sel_reg[4] <= rst_code(4'h4);
			sel_reg[5] <= rst_code(4'h5);
			sel_reg[6] <= rst_code(4'h6);
			sel_reg[7] <= rst_code(4'h7);
			sel_reg[8] <= rst_code(4'h8);
			sel_reg[9] <= rst_code(4'h9);
			sel_reg[10] <= rst_code(4'ha);
			sel_reg[11] <= rst_code(4'hb);
			sel_reg[12] <= rst_code(4'hc);
			sel_reg[13] <= rst_code(4'hd);
			sel_reg[14] <= rst_code(4'he);
			sel_reg[15] <= rst_code(4'hf);
		end else if (ce_i) begin
			if (slot_wr) begin
				sel_reg[wb_adr_i[5:2]] <= wb_dat_i[6:0];
			end
		end
	end

	// general-purpose flags register
	always @(posedge clk_i) begin
		if (rst_i) begin
			flags_reg <= `NOFS_RST_FLAGS;
		end else if (ce_i) begin
			if (flags_wr) begin
				if (wb_sel_i[0]) begin
					flags_reg[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					flags_reg[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	// source table indexed by selection code
	always @* begin
		src_next = {`NOFS_SRC_W{1'b0}};
		src_next[`NOFS_CODE_FWD] = cmd_s[0];
		src_next[`NOFS_CODE_RVS] = cmd_s[1];
		src_next[`NOFS_CODE_HOME] = cmd_s[2];
		src_next[`NOFS_CODE_START] = cmd_s[3];
		src_next[`NOFS_CODE_SSTART] = cmd_s[4];
		src_next[`NOFS_CODE_PJOG] = cmd_s[5];
		src_next[`NOFS_CODE_MJOG] = cmd_s[6];
		src_next[`NOFS_CODE_MS0 + 0] = ms_s[0];
		src_next[`NOFS_CODE_MS0 + 1] = ms_s[1];
		src_next[`NOFS_CODE_MS0 + 2] = ms_s[2];
		src_next[`NOFS_CODE_MS0 + 3] = ms_s[3];
		src_next[`NOFS_CODE_MS0 + 4] = ms_s[4];
		src_next[`NOFS_CODE_MS0 + 5] = ms_s[5];
		src_next[`NOFS_CODE_DSEL0 + 0] = dsel_s[0];
		src_next[`NOFS_CODE_DSEL0 + 1] = dsel_s[1];
		src_next[`NOFS_CODE_DSEL0 + 2] = dsel_s[2];
		src_next[`NOFS_CODE_DSEL0 + 3] = dsel_s[3];
		src_next[`NOFS_CODE_DSEL0 + 4] = dsel_s[4];
		src_next[`NOFS_CODE_DSEL0 + 5] = dsel_s[5];
		src_next[`NOFS_CODE_RELEASE] = ctl_s[0];
		src_next[`NOFS_CODE_CON] = ctl_s[1];
		src_next[`NOFS_CODE_STOP] = ctl_s[2];
		src_next[`NOFS_CODE_GFLAG0 + 0] = flags_reg[0];
		src_next[`NOFS_CODE_GFLAG0 + 1] = flags_reg[1];
		src_next[`NOFS_CODE_GFLAG0 + 2] = flags_reg[2];
		src_next[`NOFS_CODE_GFLAG0 + 3] = flags_reg[3];
		src_next[`NOFS_CODE_GFLAG0 + 4] = flags_reg[4];
		src_next[`NOFS_CODE_GFLAG0 + 5] = flags_reg[5];
		src_next[`NOFS_CODE_GFLAG0 + 6] = flags_reg[6];
		src_next[`NOFS_CODE_GFLAG0 + 7] = flags_reg[7];
		src_next[`NOFS_CODE_GFLAG0 + 8] = flags_reg[8];
		src_next[`NOFS_CODE_GFLAG0 + 9] = flags_reg[9];
		src_next[`NOFS_CODE_GFLAG0 + 10] = flags_reg[10];
		src_next[`NOFS_CODE_GFLAG0 + 11] = flags_reg[11];
		src_next[`NOFS_CODE_GFLAG0 + 12] = flags_reg[12];
		src_next[`NOFS_CODE_GFLAG0 + 13] = flags_reg[13];
		src_next[`NOFS_CODE_GFLAG0 + 14] = flags_reg[14];
		src_next[`NOFS_CODE_GFLAG0 + 15] = flags_reg[15];
		src_next[`NOFS_CODE_PLS] = sens_s[0];
		src_next[`NOFS_CODE_MLS] = sens_s[1];
		src_next[`NOFS_CODE_HOMES] = sens_s[2];
		src_next[`NOFS_CODE_SLIT] = sens_s[3];
		src_next[`NOFS_CODE_ALARM] = alarm_flag_i;
		src_next[`NOFS_CODE_WARN] = warning_flag_i;
		src_next[`NOFS_CODE_READY] = ready_flag_i;
		src_next[`NOFS_CODE_MOVE] = moving_flag_i;
		src_next[`NOFS_CODE_DONE] = position_done_flag_i;
		src_next[`NOFS_CODE_HOMEP] = home_position_flag_i;
		src_next[`NOFS_CODE_TORQUE] = torque_limit_flag_i;
		src_next[`NOFS_CODE_TIMING] = shaft_timing_pulse_i;
		src_next[`NOFS_CODE_AREA_WINDOW_FLAG_1] = area_window_flag_1_i;
		src_next[`NOFS_CODE_AREA_WINDOW_FLAG_2] = area_window_flag_2_i;
		src_next[`NOFS_CODE_AREA_WINDOW_FLAG_3] = area_window_flag_3_i;
		src_next[`NOFS_CODE_BUSY] = internal_busy_flag_i;
		src_next[`NOFS_CODE_POWER] = main_power_flag_i;
	end

	// per-slot selection, active high
	always @* begin
		status_next = `NOFS_RST_STATUS;
		status_next[0] = src_next[sel_reg[0]];
		status_next[1] = src_next[sel_reg[1]];
		status_next[2] = src_next[sel_reg[2]];
		status_next[3] = src_next[sel_reg[3]];
		status_next[4] = src_next[sel_reg[4]];
		status_next[5] = src_next[sel_reg[5]];
		status_next[6] = src_next[sel_reg[6]];
		status_next[7] = src_next[sel_reg[7]];
		status_next[8] = src_next[sel_reg[8]];
		status_next[9] = src_next[sel_reg[9]];
		status_next[10] = src_next[sel_reg[10]];
		status_next[11] = src_next[sel_reg[11]];
		status_next[12] = src_next[sel_reg[12]];
		status_next[13] = src_next[sel_reg[13]];
		status_next[14] = src_next[sel_reg[14]];
		status_next[15] = src_next[sel_reg[15]];
	end

	// registered slot outputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= `NOFS_RST_STATUS;
		end else if (ce_i) begin
			status_reg <= status_next;
		end
	end

	// read data mux, unmapped reads zero
	always @* begin
		dat_next = 32'h00000000;
		if (sel_hit(wb_adr_i)) begin
			dat_next[6:0] = sel_reg[wb_adr_i[5:2]];
		end else if (adr_hit(wb_adr_i, `NOFS_ADR_FLAGS)) begin
			dat_next[15:0] = flags_reg;
		end else if (adr_hit(wb_adr_i, `NOFS_ADR_STATUS)) begin
			dat_next[15:0] = status_reg;
		end else if (adr_hit(wb_adr_i, `NOFS_ADR_PINS)) begin
			dat_next[PIN_W-1:0] = pin_sync_reg;
		end else if (adr_hit(wb_adr_i, `NOFS_ADR_STATES)) begin
			dat_next[STATE_W-1:0] = state_vec;
		end
	end

	// bus answer, one cycle after the request
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else if (ce_i) begin
			ack_reg <= req;
			if (req && !wb_we_i) begin
				dat_reg <= dat_next;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign network_status_o = status_reg;

endmodule // nofs_selector
`default_nettype wire

// ### hdl/nofs_defines.vh
// constants for the network output function selector
// assumes inclusion by nofs_selector.v only
`ifndef NOFS_DEFINES_VH
`define NOFS_DEFINES_VH

// geometry
`define NOFS_SLOTS 16
`define NOFS_SEL_W 7
`define NOFS_SRC_W 128

// register byte offsets (wishbone, one word each)
`define NOFS_ADR_SEL_BASE 8'h00
`define NOFS_ADR_SEL_LAST 8'h3c
`define NOFS_ADR_FLAGS 8'h40
`define NOFS_ADR_STATUS 8'h44
`define NOFS_ADR_PINS 8'h48
`define NOFS_ADR_STATES 8'h4c

// selection codes
`define NOFS_CODE_UNUSED 7'h00
`define NOFS_CODE_FWD 7'h01
`define NOFS_CODE_RVS 7'h02
`define NOFS_CODE_HOME 7'h03
`define NOFS_CODE_START 7'h04
`define NOFS_CODE_SSTART 7'h05
`define NOFS_CODE_PJOG 7'h06
`define NOFS_CODE_MJOG 7'h07
`define NOFS_CODE_MS0 7'h08
`define NOFS_CODE_RELEASE 7'h10
`define NOFS_CODE_CON 7'h11
`define NOFS_CODE_STOP 7'h12
`define NOFS_CODE_GFLAG0 7'h20
`define NOFS_CODE_DSEL0 7'h30
`define NOFS_CODE_PLS 7'h3c
`define NOFS_CODE_MLS 7'h3d
`define NOFS_CODE_HOMES 7'h3e
`define NOFS_CODE_SLIT 7'h3f
`define NOFS_CODE_ALARM 7'h41
`define NOFS_CODE_WARN 7'h42
`define NOFS_CODE_READY 7'h43
`define NOFS_CODE_MOVE 7'h44
`define NOFS_CODE_DONE 7'h45
`define NOFS_CODE_HOMEP 7'h46
`define NOFS_CODE_TORQUE 7'h47
`define NOFS_CODE_TIMING 7'h48
`define NOFS_CODE_AREA_WINDOW_FLAG_1 7'h49
`define NOFS_CODE_AREA_WINDOW_FLAG_2 7'h4a
`define NOFS_CODE_AREA_WINDOW_FLAG_3 7'h4b
`define NOFS_CODE_BUSY 7'h50
`define NOFS_CODE_POWER 7'h52

// reset selection per slot
`define NOFS_RST_SEL0 7'h30
`define NOFS_RST_SEL1 7'h31
`define NOFS_RST_SEL2 7'h32
`define NOFS_RST_SEL3 7'h04
`define NOFS_RST_SEL4 7'h46
`define NOFS_RST_SEL5 7'h43
`define NOFS_RST_SEL6 7'h42
`define NOFS_RST_SEL7 7'h41
`define NOFS_RST_SEL8 7'h50
`define NOFS_RST_SEL9 7'h49
`define NOFS_RST_SEL10 7'h4a
`define NOFS_RST_SEL11 7'h4b
`define NOFS_RST_SEL12 7'h48
`define NOFS_RST_SEL13 7'h44
`define NOFS_RST_SEL14 7'h45
`define NOFS_RST_SEL15 7'h47

// other reset values
`define NOFS_RST_FLAGS 16'h0000
`define NOFS_RST_STATUS 16'h0000

`endif

// ### tb/nofs_selector_sva.sv
// checker for the network output function selector
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module nofs_selector_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic alarm_flag_i,
	input wire logic warning_flag_i,
	input wire logic ready_flag_i,
	input wire logic moving_flag_i,
	input wire logic position_done_flag_i,
	input wire logic home_position_flag_i,
	input wire logic torque_limit_flag_i,
	input wire logic internal_busy_flag_i,
	input wire logic [15:0] network_status_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic touched;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	// codes still at reset values until a write
	always @(posedge clk_i) begin
		if (rst_i) touched <= 1'b0;
		else if (wb_cyc_i && wb_we_i) touched <= 1'b1;
	end
	AST_ACK_LAT: assert property (req |=> wb_ack_o) else $error("ack late");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
	AST_RST_CLR: assert property ($past(rst_i) |-> network_status_o == 16'h0000 && !wb_ack_o)
		else $error("reset state wrong");
	AST_CE_HOLD: assert property (!ce_i |=> $stable(network_status_o) && $stable(wb_dat_o))
		else $error("moved while disabled");
	AST_UNMAPPED: assert property (req && !wb_we_i && wb_adr_i[7:2] > 6'h13 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_DEF_MAP: assert property (!touched && $past(ce_i) && !$past(rst_i) |->
		network_status_o[8:4] == $past({internal_busy_flag_i, alarm_flag_i, warning_flag_i, ready_flag_i,
		home_position_flag_i}) && network_status_o[15:13] == $past({torque_limit_flag_i,
		position_done_flag_i, moving_flag_i})) else $error("default mapping wrong");
	AST_ALARM_RISE: assert property (!touched && ce_i && $rose(alarm_flag_i) |=> network_status_o[7])
		else $error("alarm not shown");
endmodule // nofs_selector_chk
bind nofs_selector nofs_selector_chk u_chk (.*);
`default_nettype wire

// ### tb/nofs_net_master.sv
// network master model: samples the status bits each rising edge
// assumes the same clock as the selector
`timescale 1ns/1ps
`default_nettype none
module nofs_net_master (
	input wire logic clk_i,
	input wire logic [15:0] bits_i,
	output logic [15:0] seen_o
);
	always @(posedge clk_i) begin
		seen_o <= bits_i;
	end
endmodule // nofs_net_master
`default_nettype wire

// ### tb/nofs_tb.sv
// testbench for the network output function selector
// assumes hdl/nofs_selector.v and the two tb models
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 0, rst = 1, ce = 1, cyc = 0, stb = 0, we = 0, ack;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat, q;
	logic [15:0] st, seen;
	logic [127:0] s = 128'h0;
	logic [6:0] dflt [16] = '{7'h30, 7'h31, 7'h32, 7'h04, 7'h46, 7'h43, 7'h42, 7'h41,
		7'h50, 7'h49, 7'h4a, 7'h4b, 7'h48, 7'h44, 7'h45, 7'h47};
	int err_total = 0, n_compared = 0;
	always #5 clk = ~clk;
	nofs_selector u_nofs_selector (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.forward_cmd_i(s[1]), .reverse_cmd_i(s[2]), .homing_cmd_i(s[3]), .start_cmd_i(s[4]),
		.sequential_start_i(s[5]), .plus_jog_i(s[6]), .minus_jog_i(s[7]), .direct_select_i(s[13:8]),
		.motor_release_i(s[16]), .current_on_i(s[17]), .stop_cmd_i(s[18]), .data_select_i(s[53:48]),
		.plus_limit_i(s[60]), .minus_limit_i(s[61]), .home_sensor_i(s[62]), .slit_sensor_i(s[63]),
		.alarm_flag_i(s[65]), .warning_flag_i(s[66]), .ready_flag_i(s[67]), .moving_flag_i(s[68]),
		.position_done_flag_i(s[69]), .home_position_flag_i(s[70]), .torque_limit_flag_i(s[71]),
		.shaft_timing_pulse_i(s[72]), .area_window_flag_1_i(s[73]), .area_window_flag_2_i(s[74]),
		.area_window_flag_3_i(s[75]), .internal_busy_flag_i(s[80]), .main_power_flag_i(s[82]),
		.network_status_o(st));
	nofs_net_master u_nofs_net_master (.clk_i(clk), .bits_i(st), .seen_o(seen));
	function automatic bit dfn(int c);
		return (c >= 1 && c <= 13) || (c >= 16 && c <= 18) || (c >= 32 && c <= 53) ||
			(c >= 60 && c <= 63) || (c >= 65 && c <= 75) || c == 80 || c == 82;
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic cycle; ack and read data taken at the same rising edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) chk("ack", 1, 0);
		q = rdat;
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		end_of_test;
	end
	initial begin
		logic [127:0] v;
		repeat (12) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		s <= (128'h1 << 65) | (128'h1 << 67) | (128'h1 << 80);
		repeat (5) @(posedge clk);
		#1 chk("default status", 16'h01a0, seen);
		for (int i = 0; i < 16; i++) begin
			wb(0, 8'(i * 4), 0);
			chk("default code", dflt[i], q[6:0]);
		end
		$display("defaults done");
		for (int c = 0; c < 128; c++) begin
			v = dfn(c) ? (128'h1 << c) : ~128'h0;
			@(posedge clk);
			s <= v;
			wb(1, 8'h40, {16'h0, v[47:32]});
			wb(1, 8'((c % 16) * 4), 32'(c));
			wb(0, 8'((c % 16) * 4), 0);
			chk("code", 32'(c), {25'h0, q[6:0]});
			repeat (4) @(posedge clk);
			#1 chk("slot", dfn(c), seen[c % 16]);
		end
		$display("sweep done");
		wb(1, 8'h04, 32'h41);
		@(posedge clk);
		s <= 128'h0;
		repeat (5) @(posedge clk);
		s[65] <= 1;
		@(posedge clk);
		#1 chk("early", 0, seen[1]);
		@(posedge clk);
		#1 chk("latency", 1, seen[1]);
		@(posedge clk);
		ce <= 0;
		s[65] <= 0;
		repeat (4) @(posedge clk);
		#1 chk("frozen", 1, seen[1]);
		@(posedge clk);
		ce <= 1;
		repeat (3) @(posedge clk);
		#1 chk("thawed", 0, seen[1]);
		$display("timing done");
		wb(1, 8'h50, 32'hffff);
		wb(0, 8'h50, 0);
		chk("unmapped", 0, q);
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		wb(0, 8'h04, 0);
		chk("code after reset", dflt[1], q[6:0]);
		$display("reset done");
		end_of_test;
	end
endmodule // testbench
`default_nettype wire
